// ==== include/lcp_pkg.sv ====
package lcp_pkg;
   // ****************************************
   // Clock and serial timing
   // ****************************************
   localparam int unsigned SYS_CLK_HZ   = 50000000;
   localparam int unsigned BAUD_DEFAULT = 9600;
   localparam int unsigned BAUD_MAX     = 230400;
   localparam logic [15:0] DIV_DEFAULT  = 16'(SYS_CLK_HZ / BAUD_DEFAULT);
   localparam logic [15:0] DIV_MIN      = 16'(SYS_CLK_HZ / BAUD_MAX);
   localparam logic [3:0]  DATA_BITS    = 4'h8;
   localparam logic [3:0]  LAST_FRAME_BIT = 4'h9;

   // ****************************************
   // Video layout
   // ****************************************
   localparam int unsigned TAPS        = 8;
   localparam int unsigned PIX_W       = 12;
   localparam logic [15:0] LINE_WORDS  = 16'h0010;
   localparam logic        FRAME_VALID_LEVEL = 1'b0;
   localparam logic        DATA_VALID_LEVEL  = 1'b1;

   // ****************************************
   // Synchronisation mode codes
   // ****************************************
   localparam logic [2:0] SYNC_FREE     = 3'h0;
   localparam logic [2:0] SYNC_TRIG_EXP = 3'h1;
   localparam logic [2:0] SYNC_TRIG_MAX = 3'h2;
   localparam logic [2:0] SYNC_ONE_SIG  = 3'h3;
   localparam logic [2:0] SYNC_TWO_SIG  = 3'h4;

   typedef struct packed {
      logic [TAPS-1:0][PIX_W-1:0] px;
   } lcp_taps_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } lcp_byte_t;
endpackage

// ==== rtl/lcp_camera_port.sv ====
`timescale 1ns/1ps
module lcp_camera_port
(
   input  wire logic              sys_clk_i,
   input  wire logic              rst_i,
   input  wire logic              pix_clk_i,
   input  wire logic              primary_sync_input_i,
   input  wire logic              exposure_start_input_i,
   input  wire logic [2:0]        sync_mode_i,
   input  wire logic [15:0]       exp_cycles_i,
   input  wire logic              baud_set_i,
   input  wire logic [15:0]       baud_div_i,
   input  wire logic              ser_rx_i,
   output logic                   ser_tx_o,
   input  wire lcp_pkg::lcp_byte_t tx_byte_i,
   output logic                   tx_ready_o,
   output lcp_pkg::lcp_byte_t     rx_byte_o,
   output logic                   pix_reset_o,
   input  wire lcp_pkg::lcp_taps_t sensor_data_i,
   output logic                   sensor_req_o,
   output lcp_pkg::lcp_taps_t     taps_o,
   output logic                   strobe_o,
   output logic                   lval_o,
   output logic                   fval_o,
   output logic                   dval_o
);
   // ****************************************
   // Trigger and serial input synchronisers
   // ****************************************
   logic [1:0] t1_sync_reg;
   logic [1:0] t2_sync_reg;
   logic [1:0] rx_sync_reg;
   logic       t1_last_reg;
   logic       t2_last_reg;
   always_ff @(posedge sys_clk_i)
   begin
      t1_sync_reg <= {t1_sync_reg[0], primary_sync_input_i};
      t2_sync_reg <= {t2_sync_reg[0], exposure_start_input_i};
      rx_sync_reg <= {rx_sync_reg[0], ser_rx_i};
      t1_last_reg <= t1_sync_reg[1];
      t2_last_reg <= t2_sync_reg[1];
   end
   wire logic t1_rise = t1_sync_reg[1] & ~t1_last_reg;
   wire logic t1_fall = ~t1_sync_reg[1] & t1_last_reg;
   wire logic t2_rise = t2_sync_reg[1] & ~t2_last_reg;

   // ****************************************
   // Exposure control
   // ****************************************
   typedef enum logic [0:0] {EXP_IDLE, EXP_RUN} lcp_exp_t;
   lcp_exp_t    exp_state_reg, exp_state_next;
   logic [15:0] exp_cnt_reg, exp_cnt_next;
   logic        rd_tgl_reg, rd_tgl_next;
   // Zero exposure would wrap and run 65536 cycles
   function automatic logic [15:0] exp_cnt_i_safe(input logic [15:0] c);
      exp_cnt_i_safe = (c == 16'h0000) ? 16'h0001 : c;
   endfunction
   always_comb
   begin
      exp_state_next = exp_state_reg;
      exp_cnt_next   = exp_cnt_reg;
      rd_tgl_next    = rd_tgl_reg;
      case (exp_state_reg)
         EXP_IDLE:
         begin
            if (sync_mode_i == lcp_pkg::SYNC_FREE ||
                (sync_mode_i == lcp_pkg::SYNC_TRIG_EXP && t1_rise))
            begin
               exp_state_next = EXP_RUN;
               exp_cnt_next   = exp_cnt_i_safe(exp_cycles_i);
            end
            else if ((sync_mode_i == lcp_pkg::SYNC_ONE_SIG && t1_fall) ||
                     (sync_mode_i == lcp_pkg::SYNC_TWO_SIG && t2_rise) ||
                     sync_mode_i == lcp_pkg::SYNC_TRIG_MAX)
               exp_state_next = EXP_RUN;
         end
         EXP_RUN:
         begin
            case (sync_mode_i)
               lcp_pkg::SYNC_FREE, lcp_pkg::SYNC_TRIG_EXP:
               begin
                  exp_cnt_next = exp_cnt_reg - 16'h0001;
                  if (exp_cnt_reg == 16'h0001)
                  begin
                     exp_state_next = EXP_IDLE;
                     rd_tgl_next    = ~rd_tgl_reg;
                  end
               end
               lcp_pkg::SYNC_TRIG_MAX:
                  if (t1_rise)
                     rd_tgl_next = ~rd_tgl_reg;
               lcp_pkg::SYNC_ONE_SIG, lcp_pkg::SYNC_TWO_SIG:
                  if (t1_rise)
                  begin
                     exp_state_next = EXP_IDLE;
                     rd_tgl_next    = ~rd_tgl_reg;
                  end
               default:
                  exp_state_next = EXP_IDLE;
            endcase
         end
         default:
            exp_state_next = EXP_IDLE;
      endcase
   end
   always_ff @(posedge sys_clk_i)
   begin
      exp_state_reg <= rst_i ? EXP_IDLE : exp_state_next;
      exp_cnt_reg   <= rst_i ? 16'h0000 : exp_cnt_next;
      rd_tgl_reg    <= rst_i ? 1'b0 : rd_tgl_next;
   end
   // Pixels held in reset whenever no exposure runs
   assign pix_reset_o = (exp_state_reg != EXP_RUN);

   // ****************************************
   // Serial port
   // ****************************************
   logic [15:0] div_reg, div_next;
   logic [15:0] tx_cnt_reg, tx_cnt_next;
   logic [3:0]  tx_bit_reg, tx_bit_next;
   logic [9:0]  tx_sh_reg, tx_sh_next;
   logic        tx_busy_reg, tx_busy_next;
   logic [15:0] rx_cnt_reg, rx_cnt_next;
   logic [3:0]  rx_bit_reg, rx_bit_next;
   logic [7:0]  rx_sh_reg, rx_sh_next;
   logic        rx_busy_reg, rx_busy_next;
   lcp_pkg::lcp_byte_t rx_out_reg, rx_out_next;
   always_comb
   begin
      div_next     = div_reg;
      tx_cnt_next  = tx_cnt_reg;
      tx_bit_next  = tx_bit_reg;
      tx_sh_next   = tx_sh_reg;
      tx_busy_next = tx_busy_reg;
      rx_cnt_next  = rx_cnt_reg;
      rx_bit_next  = rx_bit_reg;
      rx_sh_next   = rx_sh_reg;
      rx_busy_next = rx_busy_reg;
      rx_out_next  = '{valid: 1'b0, data: rx_out_reg.data};
      // Rate change only between characters, clamped at the fastest rate
      if (baud_set_i && !tx_busy_reg && !rx_busy_reg)
         div_next = (baud_div_i < lcp_pkg::DIV_MIN) ? lcp_pkg::DIV_MIN : baud_div_i;
      if (!tx_busy_reg)
      begin
         if (tx_byte_i.valid)
         begin
            tx_busy_next = 1'b1;
            tx_sh_next   = {1'b1, tx_byte_i.data, 1'b0};
            tx_cnt_next  = div_reg;
            tx_bit_next  = 4'h0;
         end
      end
      else if (tx_cnt_reg == 16'h0001)
      begin
         tx_cnt_next = div_reg;
         tx_sh_next  = {1'b1, tx_sh_reg[9:1]};
         tx_bit_next = tx_bit_reg + 4'h1;
         if (tx_bit_reg == lcp_pkg::LAST_FRAME_BIT)
            tx_busy_next = 1'b0;
      end
      else
         tx_cnt_next = tx_cnt_reg - 16'h0001;
      // Receiver samples mid-bit; a false start is dropped
      if (!rx_busy_reg)
      begin
         if (!rx_sync_reg[1])
         begin
            rx_busy_next = 1'b1;
            rx_cnt_next  = {1'b0, div_reg[15:1]};
            rx_bit_next  = 4'h0;
         end
      end
      else if (rx_cnt_reg <= 16'h0001)
      begin
         rx_cnt_next = div_reg;
         rx_bit_next = rx_bit_reg + 4'h1;
         if (rx_bit_reg == 4'h0 && rx_sync_reg[1])
            rx_busy_next = 1'b0;
         else if (rx_bit_reg == lcp_pkg::LAST_FRAME_BIT)
         begin
            rx_busy_next = 1'b0;
            rx_out_next  = '{valid: rx_sync_reg[1], data: rx_sh_reg};
         end
         else if (rx_bit_reg != 4'h0 && rx_bit_reg <= lcp_pkg::DATA_BITS)
            rx_sh_next = {rx_sync_reg[1], rx_sh_reg[7:1]};
      end
      else
         rx_cnt_next = rx_cnt_reg - 16'h0001;
   end
   always_ff @(posedge sys_clk_i)
   begin
      div_reg     <= rst_i ? lcp_pkg::DIV_DEFAULT : div_next;
      tx_cnt_reg  <= rst_i ? 16'h0000 : tx_cnt_next;
      tx_bit_reg  <= rst_i ? 4'h0 : tx_bit_next;
      tx_sh_reg   <= rst_i ? 10'h3ff : tx_sh_next;
      tx_busy_reg <= rst_i ? 1'b0 : tx_busy_next;
      rx_cnt_reg  <= rst_i ? 16'h0000 : rx_cnt_next;
      rx_bit_reg  <= rst_i ? 4'h0 : rx_bit_next;
      rx_sh_reg   <= rst_i ? 8'h00 : rx_sh_next;
      rx_busy_reg <= rst_i ? 1'b0 : rx_busy_next;
      rx_out_reg  <= rst_i ? lcp_pkg::lcp_byte_t'('0) : rx_out_next;
   end
   assign ser_tx_o   = tx_sh_reg[0] | ~tx_busy_reg;
   assign tx_ready_o = ~tx_busy_reg;
   assign rx_byte_o  = rx_out_reg;

   // ****************************************
   // Pixel domain readout
   // ****************************************
   logic [1:0]  prst_reg;
   logic [2:0]  rd_sync_reg;
   logic [15:0] px_cnt_reg, px_cnt_next;
   logic        lval_reg, lval_next;
   lcp_pkg::lcp_taps_t taps_reg, taps_next;
   wire logic rd_start = rd_sync_reg[2] ^ rd_sync_reg[1];
   always_comb
   begin
      px_cnt_next = px_cnt_reg;
      lval_next   = lval_reg;
      taps_next   = taps_reg;
      // A readout request during a line is dropped, not queued
      if (!lval_reg && rd_start)
      begin
         lval_next   = 1'b1;
         px_cnt_next = 16'h0000;
      end
      else if (lval_reg)
      begin
         px_cnt_next = px_cnt_reg + 16'h0001;
         if (px_cnt_reg == lcp_pkg::LINE_WORDS - 16'h0001)
            lval_next = 1'b0;
      end
      if (lval_next)
         taps_next = sensor_data_i;
   end
   always_ff @(posedge pix_clk_i)
   begin
      prst_reg    <= {prst_reg[0], rst_i};
      rd_sync_reg <= {rd_sync_reg[1:0], rd_tgl_reg};
      px_cnt_reg  <= prst_reg[1] ? 16'h0000 : px_cnt_next;
      lval_reg    <= prst_reg[1] ? 1'b0 : lval_next;
      taps_reg    <= prst_reg[1] ? lcp_pkg::lcp_taps_t'('0) : taps_next;
   end
   assign sensor_req_o = lval_next;
   assign taps_o       = taps_reg;
   assign lval_o       = lval_reg;
   // Launch on pixel clock rise, receiver samples half a period later
   assign strobe_o     = ~pix_clk_i;
   assign fval_o       = lcp_pkg::FRAME_VALID_LEVEL;
   assign dval_o       = lcp_pkg::DATA_VALID_LEVEL;

   // ****************************************
   // Checks
   // ****************************************
   sequence s_dual_arm;
      exp_state_reg == EXP_IDLE && sync_mode_i == lcp_pkg::SYNC_TWO_SIG && t2_rise;
   endsequence
   sequence s_dual_stop;
      exp_state_reg == EXP_RUN && sync_mode_i == lcp_pkg::SYNC_TWO_SIG && t1_rise;
   endsequence
   AST_DUAL_START: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      s_dual_arm |=> !pix_reset_o) else $error("Dual mode exposure did not start");
   AST_DUAL_READOUT: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      s_dual_stop |=> pix_reset_o && rd_tgl_reg != $past(rd_tgl_reg))
      else $error("Dual mode readout not requested");
   AST_ONE_SIG: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      exp_state_reg == EXP_IDLE && sync_mode_i == lcp_pkg::SYNC_ONE_SIG && t1_fall |=> !pix_reset_o)
      else $error("Single signal exposure did not start");
   AST_TIMED: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      exp_state_reg == EXP_IDLE && sync_mode_i == lcp_pkg::SYNC_TRIG_EXP && t1_rise
      && exp_cycles_i == 16'h0003 |=> !pix_reset_o [*3] ##1 pix_reset_o)
      else $error("Programmed exposure length wrong");
   AST_FVAL: assert property (@(posedge pix_clk_i) !fval_o) else $error("Frame valid not low");
   AST_DVAL: assert property (@(posedge pix_clk_i) dval_o) else $error("Data valid not high");
   AST_LINE_END: assert property (@(posedge pix_clk_i) disable iff (prst_reg[1])
      lval_reg && px_cnt_reg == lcp_pkg::LINE_WORDS - 16'h0001 |=> !lval_reg)
      else $error("Line valid did not fall after last pixel");
   AST_PIX_LOAD: assert property (@(posedge pix_clk_i) disable iff (prst_reg[1])
      lval_next |=> taps_reg == $past(sensor_data_i)) else $error("Tap word not presented");
   AST_TX_IDLE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !tx_busy_reg |-> ser_tx_o) else $error("Serial line not idle high");
   AST_DIV_MIN: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      div_reg >= lcp_pkg::DIV_MIN) else $error("Baud faster than maximum");
endmodule

// ==== tb/lcp_grabber_model.sv ====
`timescale 1ns/1ps
module lcp_grabber_model
(
   input  wire logic               sys_clk_i,
   input  wire logic               strobe_i,
   input  wire logic               lval_i,
   input  wire lcp_pkg::lcp_taps_t taps_i,
   input  wire logic               ser_i,
   input  wire logic [15:0]        div_i,
   output logic                    ser_o
);
   logic [7:0]         rx_q[$];
   lcp_pkg::lcp_taps_t pix_q[$];
   logic [7:0]         sh;

   // ****************************************
   // Serial commands toward the camera
   // ****************************************
   initial ser_o = 1'b1;
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
         @(posedge sys_clk_i);
         ser_o <= f[i];
         repeat (div_i - 16'h0001) @(posedge sys_clk_i);
      end
   endtask

   // ****************************************
   // Responses and pixels from the camera
   // ****************************************
   // Mid-bit sampling, so small rate slips still land inside the bit
   always
   begin
      @(negedge ser_i);
      repeat (div_i / 2) @(posedge sys_clk_i);
      for (int i = 0; i < 8; i++)
      begin
         repeat (div_i) @(posedge sys_clk_i);
         sh[i] = ser_i;
      end
      repeat (div_i) @(posedge sys_clk_i);
      if (ser_i) rx_q.push_back(sh);
   end

   always @(posedge strobe_i)
      if (lval_i) pix_q.push_back(taps_i);
endmodule

// ==== tb/line_camera_video_and_control_port_tb.sv ====
`timescale 1ns/1ps
module line_camera_video_and_control_port_tb;
   logic               sys_clk_i;
   logic               rst_i;
   logic               pix_clk_i;
   logic               t1;
   logic               t2;
   logic [2:0]         mode;
   logic [15:0]        exp_cyc;
   logic               baud_set;
   logic [15:0]        baud_div;
   logic [15:0]        gdiv;
   wire logic          ser_rx;
   logic               ser_tx;
   lcp_pkg::lcp_byte_t tx_byte;
   logic               tx_ready;
   lcp_pkg::lcp_byte_t rx_byte;
   logic               pix_rst;
   lcp_pkg::lcp_taps_t sdata;
   logic               sreq;
   lcp_pkg::lcp_taps_t taps;
   logic               strobe;
   logic               lval;
   logic               fval;
   logic               dval;
   logic [31:0]        seed;
   logic [31:0]        pseed;
   int                 bad_count;
   int                 total_checks;
   int                 cyc;
   int                 n;
   lcp_pkg::lcp_taps_t exp_q[$];
   logic [7:0]         rxd_q[$];
   logic [7:0]         sent_tx[$];
   logic [7:0]         sent_rx[$];

   lcp_camera_port DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .pix_clk_i(pix_clk_i),
      .primary_sync_input_i(t1), .exposure_start_input_i(t2), .sync_mode_i(mode), .exp_cycles_i(exp_cyc),
      .baud_set_i(baud_set), .baud_div_i(baud_div), .ser_rx_i(ser_rx), .ser_tx_o(ser_tx), .tx_byte_i(tx_byte),
      .tx_ready_o(tx_ready), .rx_byte_o(rx_byte), .pix_reset_o(pix_rst), .sensor_data_i(sdata),
      .sensor_req_o(sreq), .taps_o(taps), .strobe_o(strobe), .lval_o(lval), .fval_o(fval), .dval_o(dval));

   lcp_grabber_model gm (.sys_clk_i(sys_clk_i), .strobe_i(strobe), .lval_i(lval), .taps_i(taps),
      .ser_i(ser_tx), .div_i(gdiv), .ser_o(ser_rx));

   // ****************************************
   // Clocks, sensor feed and monitors
   // ****************************************
   always #10 sys_clk_i = ~sys_clk_i;
   always #62.5 pix_clk_i = ~pix_clk_i;

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   always @(negedge pix_clk_i)
   begin
      pseed = lfsr(pseed);
      sdata = {pseed, ~pseed, pseed ^ 32'h5a5a5a5a};
   end
   always @(posedge pix_clk_i) if (sreq === 1'b1) exp_q.push_back(sdata);
   always @(posedge sys_clk_i) if (rx_byte.valid === 1'b1) rxd_q.push_back(rx_byte.data);
   // Ceiling well above the slow default-rate byte plus all lines
   always @(posedge sys_clk_i)
   begin
      cyc++;
      if (cyc == 90000)
      begin
         bad_count++;
         close_out();
      end
   end

   // ****************************************
   // Compare, drive and closing tasks
   // ****************************************
   task automatic cmp1(input logic g, input logic e);
      total_checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
      total_checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic cmp96(input lcp_pkg::lcp_taps_t g, input lcp_pkg::lcp_taps_t e);
      total_checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic trig(input logic a, input logic b);
      @(negedge sys_clk_i);
      t1 = a;
      t2 = b;
   endtask
   task automatic wait_pr(input logic lvl);
      for (int i = 0; i < 20 && pix_rst !== lvl; i++) @(negedge sys_clk_i);
      cmp1(pix_rst, lvl);
   endtask
   task automatic tx_send(input logic [7:0] b);
      for (int i = 0; i < 60000 && tx_ready !== 1'b1; i++) @(negedge sys_clk_i);
      tx_byte = '{1'b1, b};
      sent_tx.push_back(b);
      @(negedge sys_clk_i);
      tx_byte.valid = 1'b0;
      cmp1(tx_ready, 1'b0);
   endtask
   task automatic check_line;
      for (int i = 0; i < 400 && lval !== 1'b1; i++) @(negedge sys_clk_i);
      for (int i = 0; i < 400 && lval !== 1'b0; i++) @(negedge sys_clk_i);
      repeat (20) @(negedge sys_clk_i);
      cmp8(8'(gm.pix_q.size()), 8'(lcp_pkg::LINE_WORDS));
      cmp8(8'(exp_q.size()), 8'(lcp_pkg::LINE_WORDS));
      while (gm.pix_q.size() > 0 && exp_q.size() > 0) cmp96(gm.pix_q.pop_front(), exp_q.pop_front());
      gm.pix_q.delete();
      exp_q.delete();
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      sys_clk_i = 1'b0;
      pix_clk_i = 1'b0;
      rst_i = 1'b1;
      {t1, t2, baud_set} = 3'h0;
      mode = lcp_pkg::SYNC_TWO_SIG;
      exp_cyc = 16'h0014;
      baud_div = 16'h0000;
      gdiv = lcp_pkg::DIV_DEFAULT;
      tx_byte = '0;
      seed = 32'h32670928;
      pseed = 32'h32670928;
      repeat (12) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      rst_i = 1'b0;
      repeat (30) @(negedge sys_clk_i);
      cmp1(fval, 1'b0);
      cmp1(dval, 1'b1);
      cmp1(ser_tx, 1'b1);
      $display("test idle levels done");
      tx_send(seed[7:0]);
      for (int i = 0; i < 60000 && gm.rx_q.size() == 0; i++) @(negedge sys_clk_i);
      $display("test default rate done");
      // Rate change is only taken once the stop bit has left
      for (int i = 0; i < 5000 && tx_ready !== 1'b1; i++) @(negedge sys_clk_i);
      // Below-minimum divisor must clamp to the fastest legal rate
      baud_div = 16'h0064;
      baud_set = 1'b1;
      @(negedge sys_clk_i);
      baud_set = 1'b0;
      gdiv = lcp_pkg::DIV_MIN;
      for (int k = 0; k < 4; k++)
      begin
         seed = lfsr(seed);
         sent_rx.push_back(seed[15:8]);
         fork
            tx_send(seed[7:0]);
            gm.send(seed[15:8]);
         join
      end
      for (int i = 0; i < 5000 && (gm.rx_q.size() < 5 || rxd_q.size() < 4); i++) @(negedge sys_clk_i);
      while (sent_tx.size() > 0 && gm.rx_q.size() > 0) cmp8(gm.rx_q.pop_front(), sent_tx.pop_front());
      while (sent_rx.size() > 0 && rxd_q.size() > 0) cmp8(rxd_q.pop_front(), sent_rx.pop_front());
      cmp8(8'(sent_tx.size() + sent_rx.size()), 8'h00);
      $display("test full duplex done");
      trig(1'b0, 1'b1);
      wait_pr(1'b0);
      trig(1'b1, 1'b1);
      wait_pr(1'b1);
      check_line();
      $display("test dual signal done");
      mode = lcp_pkg::SYNC_ONE_SIG;
      trig(1'b0, 1'b0);
      wait_pr(1'b0);
      trig(1'b1, 1'b0);
      wait_pr(1'b1);
      check_line();
      $display("test one signal done");
      mode = lcp_pkg::SYNC_TRIG_EXP;
      exp_cyc = 16'h0003;
      trig(1'b0, 1'b0);
      trig(1'b1, 1'b0);
      wait_pr(1'b0);
      n = 0;
      while (pix_rst === 1'b0 && n < 100)
      begin
         n++;
         @(negedge sys_clk_i);
      end
      cmp8(8'(n), exp_cyc[7:0]);
      check_line();
      $display("test programmed exposure done");
      // Long period so one line ends well before the next readout
      exp_cyc = 16'h00c8;
      mode = lcp_pkg::SYNC_FREE;
      check_line();
      mode = lcp_pkg::SYNC_TRIG_MAX;
      $display("test free run done");
      trig(1'b0, 1'b0);
      trig(1'b1, 1'b0);
      check_line();
      $display("test maximum exposure done");
      close_out();
   end
endmodule
